// ==== common/rac_defs.vh ====
// Constants for the region attribute and cache management block
`ifndef RAC_DEFS_VH
`define RAC_DEFS_VH
// Control register move codes of the four region registers
`define RAC_SEL_DREG0     12'h004
`define RAC_SEL_DREG1     12'h005
`define RAC_SEL_IREG0     12'h006
`define RAC_SEL_IREG1     12'h007
// Control register move code of the cache control register
`define RAC_SEL_CCTL      12'h002
// Region register fields
`define RAC_BASE_HI       31
`define RAC_BASE_LO       24
`define RAC_MASK_HI       23
`define RAC_MASK_LO       16
`define RAC_EN_BIT        15
`define RAC_PRIV_HI       14
`define RAC_PRIV_LO       13
`define RAC_POL_HI        6
`define RAC_POL_LO        5
`define RAC_WP_BIT        2
// Readable bits of a region register
`define RAC_DREG_RMASK    32'hffffe064
`define RAC_IREG_RMASK    32'hffffe060
// Cache control fields
`define RAC_CC_DON        31
`define RAC_CC_DKEEP      28
`define RAC_CC_DFLUSH     24
`define RAC_CC_DDEF_HI    9
`define RAC_CC_DDEF_LO    8
`define RAC_CC_ION        15
`define RAC_CC_IKEEP      12
`define RAC_CC_IDEF       10
`define RAC_CC_IFLUSH     8
`define RAC_CC_RESET      32'h00000000
// Cache policies
`define RAC_POL_WT        2'h0
`define RAC_POL_CB        2'h1
`define RAC_POL_NCP       2'h2
`define RAC_POL_NCI       2'h3
// Cache geometry
`define RAC_WAYS          4
`define RAC_DSETS         128
`define RAC_ISETS         256
`endif

// ==== core/rac_region_match.v ====
// One region register compare: base, mask, enable and privilege
`timescale 1ns/10ps
`include "rac_defs.vh"
module rac_region_match (
  input  wire [31:0] reg_val,   // Region register contents
  input  wire [7:0]  addr_hi,   // Access address bits 31..24
  input  wire        is_super,  // Access is supervisor mode
  output wire        hit        // Region matches this access
);
  wire [7:0] base;
  wire [7:0] mask;
  wire [1:0] priv;
  wire       addr_ok;
  wire       priv_ok;

  assign base = reg_val[`RAC_BASE_HI:`RAC_BASE_LO];
  assign mask = reg_val[`RAC_MASK_HI:`RAC_MASK_LO];
  assign priv = reg_val[`RAC_PRIV_HI:`RAC_PRIV_LO];
  assign addr_ok = (((base ^ addr_hi) & ~mask) == 8'h00);
  assign priv_ok = priv[1] | (priv[0] == is_super);
  assign hit = reg_val[`RAC_EN_BIT] & addr_ok & priv_ok;
endmodule

// ==== core/rac_region_cache.v ====
// Region attribute matcher with cache control and line push sequencing
`timescale 1ns/10ps
`include "rac_defs.vh"
// Notes on behaviour
// - Registers 0,1 data; 2,3 instruction
// - Lowest numbered matching register wins
// - Full words; reserved bits read zero
// - Move codes 4..7; debug may read
// - Base compares address bits 31..24
// - Set mask bit ignores base bit
// - Enable bit gates register; reset clears
// - Privilege field: user, supervisor, any
// - Policy field selects cache mode
// - Data write protect bit blocks writes
// - Reset clears cache control, not contents
// - Push indexes directory, writes modified data lines back
// - Keep-valid bit decides invalidate after push
// - Four ways; 512 data, 1024 instruction
// - Push and flush ignore enable bits
// - Disabled cache keeps contents, no service
// - No hit uses default policy; local memory hit uses NCP
// - Flush all clears valids, stalls, self-clears
module rac_region_cache #(
  parameter DSETS = `RAC_DSETS,  // Data cache sets
  parameter ISETS = `RAC_ISETS   // Instruction cache sets
) (
  input  wire        clock,         // Core clock
  input  wire        sys_rst,       // Synchronous reset, active high
  input  wire        ctl_wr,        // Control register write strobe
  input  wire        ctl_rd,        // Control register read strobe
  input  wire        ctl_dbg,       // Access comes from debug unit
  input  wire [11:0] ctl_reg_select_code, // Control register move code
  input  wire [31:0] ctl_wdata,     // Control register write data
  input  wire        d_req,         // Data access request
  input  wire        d_write,       // Data access is a write
  input  wire        d_super,       // Data access is supervisor
  input  wire [31:0] d_addr,        // Data access address
  input  wire        d_local_hit,   // Data access hits local memory base
  input  wire        i_req,         // Instruction fetch request
  input  wire        i_super,       // Fetch is supervisor
  input  wire [31:0] i_addr,        // Fetch address
  input  wire        i_local_hit,   // Fetch hits local memory base
  input  wire        push_req,      // Line push request
  input  wire        push_icache,   // Push targets instruction cache
  input  wire [9:0]  push_index,    // Push set and way index
  input  wire        push_dirty,    // Selected line is modified
  input  wire        wb_done,       // Line write back finished
  output reg  [31:0] ctl_rdata,     // Control register read data
  output reg         ctl_err,       // Refused control access
  output reg  [1:0]  d_policy,      // Data access cache policy
  output reg         d_cache_use,   // Data cache services access
  output reg         d_err,         // Data access error
  output reg  [1:0]  i_policy,      // Fetch cache policy
  output reg         i_cache_use,   // Instruction cache services fetch
  output reg         mem_stall,     // Local memory accesses stalled
  output reg         wb_req,        // Write back selected line
  output reg         push_busy,     // Push in progress
  output reg  [31:0] cctl_q         // Cache control register
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WB   = 2'h1;
  localparam ST_DONE = 2'h2;

  reg  [31:0] region_attr_reg [0:3];
  reg  [DSETS*`RAC_WAYS-1:0] dvalid_q;
  reg  [ISETS*`RAC_WAYS-1:0] ivalid_q;
  reg  [8:0]  dflush_idx_q;
  reg  [9:0]  iflush_idx_q;
  reg  [1:0]  push_st_q;
  reg         push_ic_q;
  reg  [9:0]  push_idx_q;
  wire [3:0]  hit;
  wire        data_flush_all;
  wire        instr_flush_all;
  wire        data_cache_on;
  wire        instr_cache_on;
  wire        data_push_keep_valid;
  wire        instr_push_keep_valid;
  wire [1:0]  data_default_policy;
  wire        instr_default_policy;
  reg  [1:0]  d_pol_d;
  reg  [1:0]  i_pol_d;
  reg         d_prot_d;
  integer     n;

  function cacheable;
    input [1:0] pol;
    begin
      cacheable = ~pol[1];
    end
  endfunction

  assign data_flush_all        = cctl_q[`RAC_CC_DFLUSH];
  assign instr_flush_all       = cctl_q[`RAC_CC_IFLUSH];
  assign data_cache_on         = cctl_q[`RAC_CC_DON];
  assign instr_cache_on        = cctl_q[`RAC_CC_ION];
  assign data_push_keep_valid  = cctl_q[`RAC_CC_DKEEP];
  assign instr_push_keep_valid = cctl_q[`RAC_CC_IKEEP];
  assign data_default_policy   = cctl_q[`RAC_CC_DDEF_HI:`RAC_CC_DDEF_LO];
  assign instr_default_policy  = cctl_q[`RAC_CC_IDEF];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_match
      // data class for 0,1; instruction class for 2,3
      rac_region_match u_match (
        .reg_val  (region_attr_reg[g]),
        .addr_hi  (g < 2 ? d_addr[31:24] : i_addr[31:24]),
        .is_super (g < 2 ? d_super : i_super),
        .hit      (hit[g])
      );
    end
  endgenerate

  // Policy resolution per access class
  always @* begin
    if (hit[0]) begin
      d_pol_d  = region_attr_reg[0][`RAC_POL_HI:`RAC_POL_LO];
      d_prot_d = region_attr_reg[0][`RAC_WP_BIT];
    end else if (hit[1]) begin
      d_pol_d  = region_attr_reg[1][`RAC_POL_HI:`RAC_POL_LO];
      d_prot_d = region_attr_reg[1][`RAC_WP_BIT];
    end else if (d_local_hit) begin
      d_pol_d  = `RAC_POL_NCP;
      d_prot_d = 1'b0;
    end else begin
      d_pol_d  = data_default_policy;
      d_prot_d = 1'b0;
    end
    if (hit[2])
      i_pol_d = region_attr_reg[2][`RAC_POL_HI:`RAC_POL_LO];
    else if (hit[3])
      i_pol_d = region_attr_reg[3][`RAC_POL_HI:`RAC_POL_LO];
    else if (i_local_hit)
      i_pol_d = `RAC_POL_NCP;
    else
      i_pol_d = instr_default_policy ? `RAC_POL_NCP : `RAC_POL_WT;
  end

  // Access outputs
  always @(posedge clock) begin
    if (sys_rst) begin
      d_policy    <= 2'h0;
      d_cache_use <= 1'b0;
      d_err       <= 1'b0;
      i_policy    <= 2'h0;
      i_cache_use <= 1'b0;
    end else begin
      d_policy    <= d_pol_d;
      i_policy    <= i_pol_d;
      d_err       <= d_req & d_write & d_prot_d;
      d_cache_use <= d_req & data_cache_on & cacheable(d_pol_d) & ~(d_write & d_prot_d) & ~mem_stall;
      i_cache_use <= i_req & instr_cache_on & cacheable(i_pol_d) & ~mem_stall;
    end
  end

  // Region registers: enable cleared at reset, other fields kept
  always @(posedge clock) begin
    if (sys_rst) begin
      for (n = 0; n < 4; n = n + 1)
        region_attr_reg[n][`RAC_EN_BIT] <= 1'b0;
    end else if (ctl_wr) begin
      // full word writes by move code
      case (ctl_reg_select_code)
        `RAC_SEL_DREG0: region_attr_reg[0] <= ctl_wdata & `RAC_DREG_RMASK;
        `RAC_SEL_DREG1: region_attr_reg[1] <= ctl_wdata & `RAC_DREG_RMASK;
        // bit 2 reserved for instruction registers
        `RAC_SEL_IREG0: region_attr_reg[2] <= ctl_wdata & `RAC_IREG_RMASK;
        `RAC_SEL_IREG1: region_attr_reg[3] <= ctl_wdata & `RAC_IREG_RMASK;
        default: ;
      endcase
    end
  end

  // Control register read port; core reads are refused
  always @(posedge clock) begin
    if (sys_rst) begin
      ctl_rdata <= 32'h00000000;
      ctl_err   <= 1'b0;
    end else begin
      ctl_rdata <= 32'h00000000;
      ctl_err   <= 1'b0;
      if (ctl_rd) begin
        if (!ctl_dbg) begin
          ctl_err <= 1'b1;
        end else begin
          case (ctl_reg_select_code)
            `RAC_SEL_DREG0: ctl_rdata <= region_attr_reg[0] & `RAC_DREG_RMASK;
            `RAC_SEL_DREG1: ctl_rdata <= region_attr_reg[1] & `RAC_DREG_RMASK;
            `RAC_SEL_IREG0: ctl_rdata <= region_attr_reg[2] & `RAC_IREG_RMASK;
            `RAC_SEL_IREG1: ctl_rdata <= region_attr_reg[3] & `RAC_IREG_RMASK;
            `RAC_SEL_CCTL:  ctl_rdata <= cctl_q;
            default:        ctl_err   <= 1'b1;
          endcase
        end
      end
    end
  end

  // Cache control register and sequential flush engines
  always @(posedge clock) begin
    if (sys_rst) begin
      cctl_q       <= `RAC_CC_RESET;
      dflush_idx_q <= 9'h000;
      iflush_idx_q <= 10'h000;
    end else begin
      // step through valid bits, then self clear
      if (data_flush_all) begin
        dflush_idx_q <= dflush_idx_q + 9'h001;
        if (dflush_idx_q == DSETS*`RAC_WAYS-1) begin
          cctl_q[`RAC_CC_DFLUSH] <= 1'b0;
          dflush_idx_q           <= 9'h000;
        end
      end
      if (instr_flush_all) begin
        iflush_idx_q <= iflush_idx_q + 10'h001;
        if (iflush_idx_q == ISETS*`RAC_WAYS-1) begin
          cctl_q[`RAC_CC_IFLUSH] <= 1'b0;
          iflush_idx_q           <= 10'h000;
        end
      end
      // Software write last, so a new flush request beats the self clear
      if (ctl_wr && ctl_reg_select_code == `RAC_SEL_CCTL)
        cctl_q <= ctl_wdata;
    end
  end

  // Valid arrays; not touched by reset, only by flush and push
  always @(posedge clock) begin
    if (data_flush_all)
      dvalid_q[dflush_idx_q] <= 1'b0;
    if (instr_flush_all)
      ivalid_q[iflush_idx_q] <= 1'b0;
    if (!sys_rst && push_st_q == ST_DONE) begin
      if (push_ic_q && !instr_push_keep_valid)
        ivalid_q[push_idx_q] <= 1'b0;
      if (!push_ic_q && !data_push_keep_valid)
        dvalid_q[push_idx_q[8:0]] <= 1'b0;
    end
  end

  // Line push sequencer
  always @(posedge clock) begin
    if (sys_rst) begin
      push_st_q  <= ST_IDLE;
      push_ic_q  <= 1'b0;
      push_idx_q <= 10'h000;
      wb_req     <= 1'b0;
      push_busy  <= 1'b0;
      mem_stall  <= 1'b0;
    end else begin
      mem_stall <= data_flush_all | instr_flush_all;
      case (push_st_q)
        ST_IDLE: begin
          // index is set and way, enable ignored
          if (push_req) begin
            push_ic_q  <= push_icache;
            push_idx_q <= push_icache ? push_index : {1'b0, push_index[8:0]};
            push_busy  <= 1'b1;
            if (!push_icache && push_dirty) begin
              wb_req    <= 1'b1;
              push_st_q <= ST_WB;
            end else begin
              push_st_q <= ST_DONE;
            end
          end
        end
        ST_WB: begin
          if (wb_done) begin
            wb_req    <= 1'b0;
            push_st_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          push_busy <= 1'b0;
          push_st_q <= ST_IDLE;
        end
        default: push_st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== sim/rac_region_cache_assertions.sv ====
// Assertion checker for the region attribute and cache block
`timescale 1ns/10ps
module rac_region_cache_assertions (
  input wire        clock,               // Core clock
  input wire        sys_rst,             // Synchronous reset
  input wire        ctl_rd,              // Read strobe
  input wire        ctl_dbg,             // Debug access
  input wire [11:0] ctl_reg_select_code, // Move code
  input wire [31:0] ctl_rdata,           // Read data
  input wire        ctl_err,             // Refused access
  input wire        d_req,               // Data request
  input wire        d_write,             // Data write
  input wire [1:0]  d_policy,            // Data policy
  input wire        d_cache_use,         // Data cache used
  input wire        d_err,               // Data error
  input wire        push_req,            // Push request
  input wire        push_icache,         // Push to instr cache
  input wire        push_dirty,          // Line modified
  input wire        push_busy,           // Push running
  input wire        wb_req,              // Write back request
  input wire        wb_done,             // Write back done
  input wire        mem_stall,           // Stall
  input wire [31:0] cctl_q               // Cache control
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_dirty_push;
    push_req && !push_busy && push_dirty && !push_icache;
  endsequence
  sequence s_wb_end;
    !wb_req && push_busy ##1 !push_busy;
  endsequence
  AST_CCTL_RST: assert property (disable iff (1'b0) $fell(sys_rst) |-> cctl_q == 32'h0)
    else $error("cache control not clear after reset");
  AST_CORE_RD: assert property (ctl_rd && !ctl_dbg |=> ctl_err && ctl_rdata == 32'h0)
    else $error("core read of region register not refused");
  AST_RSV_ZERO: assert property (ctl_rd && ctl_dbg && ctl_reg_select_code[11:2] == 10'h001
    |=> (ctl_rdata & 32'h00001f9b) == 32'h0) else $error("reserved region bits read nonzero");
  AST_IRSV_ZERO: assert property (ctl_rd && ctl_dbg && ctl_reg_select_code[11:1] == 11'h003
    |=> !ctl_rdata[2]) else $error("instruction region bit 2 read nonzero");
  AST_ERR_WR: assert property (d_err |-> $past(d_req) && $past(d_write) && !d_cache_use)
    else $error("access error without a write");
  AST_USE_CACHED: assert property (d_cache_use |-> !d_policy[1])
    else $error("cache used for uncached policy");
  AST_OFF_NOUSE: assert property (!cctl_q[31] |=> !d_cache_use)
    else $error("disabled data cache serviced access");
  AST_FLUSH_STALL: assert property (cctl_q[24] |=> mem_stall)
    else $error("no stall during flush");
  AST_FLUSH_DONE: assert property ($rose(cctl_q[24]) |-> ##[1:600] !cctl_q[24])
    else $error("data flush bit did not self clear");
  AST_PUSH_TAKE: assert property (push_req && !push_busy |=> push_busy)
    else $error("push not taken");
  AST_WB_START: assert property (s_dirty_push |=> wb_req)
    else $error("modified line not written back");
  AST_WB_HOLD: assert property (wb_req && !wb_done |=> wb_req)
    else $error("write back request dropped early");
  AST_WB_END: assert property (wb_req && wb_done |=> s_wb_end)
    else $error("push did not finish after write back");
  AST_IPUSH_NOWB: assert property (push_req && !push_busy && push_icache |=> !wb_req)
    else $error("instruction push wrote back");
endmodule
bind rac_region_cache rac_region_cache_assertions i_chk (.clock, .sys_rst, .ctl_rd, .ctl_dbg,
  .ctl_reg_select_code, .ctl_rdata, .ctl_err, .d_req, .d_write, .d_policy, .d_cache_use, .d_err,
  .push_req, .push_icache, .push_dirty, .push_busy, .wb_req, .wb_done, .mem_stall, .cctl_q);

// ==== sim/rac_wb_partner.sv ====
// Local memory side model answering line write backs
`timescale 1ns/10ps
module rac_wb_partner (
  input  wire       clock,   // Core clock
  input  wire       sys_rst, // Synchronous reset
  input  wire       wb_req,  // Write back request
  input  wire [3:0] dly,     // Answer delay in cycles
  output reg        wb_done  // Write back finished pulse
);
  reg [3:0] cnt_q;
  always @(posedge clock) begin
    if (sys_rst || !wb_req || wb_done) begin
      cnt_q   <= 4'h0;
      wb_done <= 1'b0;
    end else if (cnt_q == dly) begin
      wb_done <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// ==== sim/rac_region_cache_tb.sv ====
// Self-checking testbench for the region attribute and cache block
`timescale 1ns/10ps
module rac_region_cache_tb;
  reg         clock, sys_rst, ctl_wr, ctl_rd, ctl_dbg, d_req, d_write, d_super, i_req, i_super;
  reg         push_req, push_icache, push_dirty, cache_on, d_local_hit, i_local_hit;
  reg  [11:0] ctl_reg_select_code;
  reg  [31:0] ctl_wdata, d_addr, i_addr;
  reg  [9:0]  push_index;
  reg  [3:0]  dly;
  wire [31:0] ctl_rdata, cctl_q;
  wire [1:0]  d_policy, i_policy;
  wire        ctl_err, d_cache_use, d_err, i_cache_use, mem_stall, wb_req, push_busy, wb_done;
  integer     bad_count, comparisons, cycles, i, n;
  reg  [31:0] rows [0:6];
  reg  [31:0] rv [0:3];
  rac_region_cache i_dut (.clock, .sys_rst, .ctl_wr, .ctl_rd, .ctl_dbg, .ctl_reg_select_code,
    .ctl_wdata, .d_req, .d_write, .d_super, .d_addr, .d_local_hit, .i_req, .i_super, .i_addr,
    .i_local_hit, .push_req, .push_icache, .push_index, .push_dirty, .wb_done, .ctl_rdata,
    .ctl_err, .d_policy, .d_cache_use, .d_err, .i_policy, .i_cache_use, .mem_stall, .wb_req,
    .push_busy, .cctl_q);
  rac_wb_partner i_mem (.clock, .sys_rst, .wb_req, .dly, .wb_done);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task ctl(input wr, input dbg, input [11:0] code, input [31:0] wd);
    begin
      @(posedge clock);
      ctl_wr              <= wr;
      ctl_rd              <= ~wr;
      ctl_dbg             <= dbg;
      ctl_reg_select_code <= code;
      ctl_wdata           <= wd;
      @(posedge clock);
      ctl_wr <= 1'b0;
      ctl_rd <= 1'b0;
      #1;
    end
  endtask
  // Row: flags dsup,dwr,derr,isup; data addr hi; instr addr hi; data policy; instr policy; local hit; instr check
  task acc(input [31:0] r);
    begin
      @(posedge clock);
      d_req   <= 1'b1;
      d_super <= r[31];
      d_write <= r[30];
      d_addr  <= {r[27:20], 24'h000100};
      i_req   <= 1'b1;
      i_super <= r[28];
      i_addr  <= {r[19:12], 24'h000040};
      d_local_hit <= r[1];
      i_local_hit <= r[1];
      @(posedge clock);
      #1;
      check(d_policy, r[9:8]);
      check(d_err, r[29]);
      check(d_cache_use, cache_on & ~r[9] & ~r[29]);
      if (r[0]) begin
        check(i_policy, r[5:4]);
        check(i_cache_use, cache_on & ~r[5]);
      end
    end
  endtask
  task push(input ic, input [3:0] dl);
    begin
      @(posedge clock);
      push_req    <= 1'b1;
      push_icache <= ic;
      push_dirty  <= 1'b1;
      push_index  <= 10'h1ff;
      dly         <= dl;
      @(posedge clock);
      push_req <= 1'b0;
      #1;
      check(push_busy, 1);
      check(wb_req, !ic);
      for (n = 0; n < 30 && push_busy; n = n + 1) begin
        @(posedge clock);
        #1;
      end
      check(n < 30, 1);
    end
  endtask
  initial begin
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    cache_on = 0;
    sys_rst = 1'b1;
    {ctl_wr, ctl_rd, ctl_dbg, d_req, d_write, d_super, i_req, i_super, push_req, push_icache} = 10'h0;
    {d_local_hit, i_local_hit} = 2'h0;
    {push_dirty, ctl_reg_select_code, ctl_wdata, d_addr, i_addr, push_index, dly} = 0;
    rows[0] = 32'hf1020101;
    rows[1] = 32'h01020123;
    rows[2] = 32'h012a0321;
    rows[3] = 32'h912a0221;
    rows[4] = 32'h51320301;
    rows[5] = 32'h014a0221;
    rows[6] = 32'h01440223;
    rv[0] = 32'h1000c0a5;
    rv[1] = 32'h10038060; // peripheral window mapped uncached
    rv[2] = 32'h2000a004;
    rv[3] = 32'h2080c040;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    acc(32'hc1020000);
    push(0, 0);
    push(0, 9);
    push(1, 0);
    ctl(1, 0, 12'h002, 32'h01000100);
    for (n = 0; n < 1100 && (cctl_q[24] || cctl_q[8]); n = n + 1) begin
      @(posedge clock);
      #1;
    end
    check(n < 1100, 1);
    @(posedge clock);
    #1;
    check(mem_stall, 0);
    for (i = 0; i < 4; i = i + 1)
      ctl(1, 0, 12'h004 + i, rv[i]);
    ctl(1, 0, 12'h002, 32'h80008200);
    cache_on = 1;
    for (i = 0; i < 4; i = i + 1) begin
      ctl(0, 1, 12'h004 + i, 32'h0);
      check(ctl_rdata, rv[i] & (i < 2 ? 32'hffffe064 : 32'hffffe060));
      check(ctl_err, 0);
    end
    ctl(0, 0, 12'h004, 32'h0);
    check(ctl_err, 1);
    check(ctl_rdata, 0);
    ctl(0, 1, 12'h008, 32'h0);
    check(ctl_err, 1);
    for (i = 0; i < 7; i = i + 1)
      acc(rows[i]);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    cache_on = 0;
    #1;
    check(cctl_q, 0);
    acc(32'hc1020000);
    end_sim;
  end
endmodule
